// [verilog/rsia_pkg.sv]
// Contract
// - full stack push wraps pointer to 0x10
// - reset option: overflow resets, level zero kept
// - overflow with option sets overflow flag, resets
// - underflow with option sets underflow flag, resets
// - window access goes to pointer address
// - pointer at window address reads zero
// - pointer at window address suppresses write
// - pointer is high byte and low byte
// - indirect space decodes into three regions
package rsia_pkg;
  localparam int unsigned STACK_DEPTH    = 16;
  localparam int unsigned STACK_PTR_W    = 5;
  localparam int unsigned RET_ADDR_W     = 15;
  localparam int unsigned DATA_W         = 8;
  localparam int unsigned IND_ADDR_W     = 16;
  localparam logic [4:0]  STACK_PTR_RST  = 5'h1f;
  localparam logic [4:0]  STACK_PTR_WRAP = 5'h10;
  localparam logic [4:0]  STACK_PTR_TOP  = 5'h0f;
  localparam logic [4:0]  STACK_PTR_EMPTY = 5'h1f;
  localparam logic [15:0] WINDOW0_ADDR   = 16'h0000;
  localparam logic [15:0] WINDOW1_ADDR   = 16'h0001;
  localparam logic [15:0] LINEAR_BASE    = 16'h2000;
  localparam logic [15:0] FLASH_BASE     = 16'h8000;
  localparam logic [7:0]  ZERO_BYTE      = 8'h00;

  typedef enum logic [1:0] {
    RSIA_REG_TRAD   = 2'b00,
    RSIA_REG_LINEAR = 2'b01,
    RSIA_REG_FLASH  = 2'b10
  } rsia_region_e;

  typedef struct packed {
    logic                  valid;
    logic                  write;
    logic                  sel;
    logic [DATA_W-1:0]     wdata;
  } rsia_ind_req_s;

  typedef struct packed {
    logic                  rd;
    logic                  wr;
    rsia_region_e          region;
    logic [IND_ADDR_W-1:0] addr;
    logic [DATA_W-1:0]     wdata;
  } rsia_mem_req_s;
endpackage : rsia_pkg

// [verilog/rsia_core.sv]
module rsia_core
  import rsia_pkg::*;
#(
  parameter logic [15:0] LINEAR_START = LINEAR_BASE,
  parameter logic [15:0] FLASH_START  = FLASH_BASE
) (
  input  wire logic                  core_clk,
  input  wire logic                  rst_n,
  input  wire logic                  stack_reset_enable,
  input  wire logic                  push,
  input  wire logic                  pop,
  input  wire logic [RET_ADDR_W-1:0] push_addr,
  output logic      [RET_ADDR_W-1:0] top_return,
  output logic      [STACK_PTR_W-1:0] stack_level_pointer,
  output logic                       device_reset_req,
  output logic                       stack_overflow_flag,
  output logic                       stack_underflow_flag,
  input  wire logic                  cause_clear,
  input  wire logic [1:0]            ptr_wr_high,
  input  wire logic [1:0]            ptr_wr_low,
  input  wire logic [DATA_W-1:0]     ptr_wdata,
  output logic      [IND_ADDR_W-1:0] file_select_pointer0,
  output logic      [IND_ADDR_W-1:0] file_select_pointer1,
  input  wire rsia_ind_req_s         ind_req,
  output rsia_mem_req_s              mem_req,
  input  wire logic [DATA_W-1:0]     mem_rdata,
  output logic      [DATA_W-1:0]     ind_rdata
);
  // return levels; no reset, the level pointer says what is live
  logic [RET_ADDR_W-1:0]  stack_mem [STACK_DEPTH];
  logic                   self_window_q;

  // stack level decode
  wire                    at_top;
  wire                    at_empty;
  wire                    overflow;
  wire                    underflow;
  wire                    ovf_reset;
  wire                    unf_reset;
  wire                    any_reset;
  wire                    store_en;
  wire [STACK_PTR_W-1:0]  inc_ptr;
  wire [STACK_PTR_W-1:0]  dec_ptr;
  wire [STACK_PTR_W-1:0]  next_ptr;
  wire [3:0]              wr_slot;
  wire [3:0]              next_slot;
  wire [RET_ADDR_W-1:0]   level_word;
  wire [RET_ADDR_W-1:0]   next_top_return;
  wire                    next_overflow_flag;
  wire                    next_underflow_flag;
  wire                    next_reset_req;

  // indirect access decode
  wire [IND_ADDR_W-1:0]   ind_addr;
  wire                    hit_window0;
  wire                    hit_window1;
  wire                    self_window;
  wire                    in_flash;
  wire                    in_linear;
  wire                    ind_rd_en;
  wire                    ind_wr_en;
  wire                    next_self_window;
  rsia_region_e           region;

  assign at_top    = (stack_level_pointer == STACK_PTR_TOP);
  assign at_empty  = (stack_level_pointer == STACK_PTR_EMPTY);
  assign overflow  = push && at_top;
  // a pop beside a push loses, the call decides the level
  assign underflow = pop && !push && at_empty;

  assign ovf_reset = overflow && stack_reset_enable;
  assign unf_reset = underflow && stack_reset_enable;
  assign any_reset = ovf_reset || unf_reset;

  assign inc_ptr   = stack_level_pointer + 5'h01;
  assign dec_ptr   = stack_level_pointer - 5'h01;

  assign next_ptr  = any_reset ? STACK_PTR_RST  :
                     overflow  ? STACK_PTR_WRAP :
                     push      ? inc_ptr        :
                     pop       ? dec_ptr        :
                                 stack_level_pointer;

  // 0x10 aliases level zero, so only the low four bits index storage
  assign wr_slot    = inc_ptr[3:0];
  assign next_slot  = next_ptr[3:0];
  assign level_word = stack_mem[next_slot];

  assign store_en   = push && !ovf_reset;

  // top follows a store at once, else it reads the new level
  assign next_top_return = store_en ? push_addr : level_word;

  // overflow and underflow cause flags
  // set beats clear so no cause is lost
  assign next_overflow_flag  = ovf_reset   ? 1'b1 :
                               cause_clear ? 1'b0 : stack_overflow_flag;
  assign next_underflow_flag = unf_reset   ? 1'b1 :
                               cause_clear ? 1'b0 : stack_underflow_flag;

  // one-cycle request, the system reset logic acts on it
  assign next_reset_req = any_reset;

  // state
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      stack_level_pointer <= STACK_PTR_RST;
    end else begin
      stack_level_pointer <= next_ptr;
    end
  end

  always_ff @(posedge core_clk) begin
    if (store_en) begin
      stack_mem[wr_slot] <= push_addr;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      top_return <= '0;
    end else begin
      top_return <= next_top_return;
    end
  end

  // flags survive the reset they trigger
  always_ff @(posedge core_clk) begin
    stack_overflow_flag <= next_overflow_flag;
  end
  always_ff @(posedge core_clk) begin
    stack_underflow_flag <= next_underflow_flag;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      device_reset_req <= 1'b0;
    end else begin
      device_reset_req <= next_reset_req;
    end
  end

  // after reset both pointers aim at a window, so reads give zero
  // byte strobes are separate: a pointer is half new for a cycle
  // high and low concatenated
  for (genvar g = 0; g < 2; g++) begin : g_ptr
    logic [DATA_W-1:0]     pointer_high_byte;
    logic [DATA_W-1:0]     pointer_low_byte;
    wire                   load_high;
    wire                   load_low;
    wire [IND_ADDR_W-1:0]  pointer_word;

    assign load_high = ptr_wr_high[g];
    assign load_low  = ptr_wr_low[g];

    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        pointer_high_byte <= ZERO_BYTE;
      end else if (load_high) begin
        pointer_high_byte <= ptr_wdata;
      end
    end

    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        pointer_low_byte <= ZERO_BYTE;
      end else if (load_low) begin
        pointer_low_byte <= ptr_wdata;
      end
    end

    assign pointer_word = {pointer_high_byte, pointer_low_byte};
  end

  assign file_select_pointer0 = g_ptr[0].pointer_word;
  assign file_select_pointer1 = g_ptr[1].pointer_word;

  assign ind_addr    = ind_req.sel ? file_select_pointer1 : file_select_pointer0;
  assign hit_window0 = (ind_addr == WINDOW0_ADDR);
  assign hit_window1 = (ind_addr == WINDOW1_ADDR);
  assign self_window = hit_window0 || hit_window1;

  // boundaries are parameters
  // boundaries must rise: linear start below flash start
  assign in_flash    = (ind_addr >= FLASH_START);
  assign in_linear   = (ind_addr >= LINEAR_START);
  assign region      = in_flash  ? RSIA_REG_FLASH  :
                       in_linear ? RSIA_REG_LINEAR :
                                   RSIA_REG_TRAD;

  assign ind_rd_en   = ind_req.valid && !ind_req.write;
  assign ind_wr_en   = ind_req.valid && ind_req.write;

  // strobes are combinational so memory sees them in the same cycle
  // self write suppressed
  assign mem_req.wr     = ind_wr_en && !self_window;
  assign mem_req.rd     = ind_rd_en && !self_window;
  assign mem_req.region = region;
  assign mem_req.addr   = ind_addr;
  assign mem_req.wdata  = ind_req.wdata;

  // the read answer lands a cycle late, so the window hit is kept
  assign next_self_window = ind_rd_en ? self_window : self_window_q;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      self_window_q <= 1'b0;
    end else begin
      self_window_q <= next_self_window;
    end
  end

  assign ind_rdata = self_window_q ? ZERO_BYTE : mem_rdata;
endmodule : rsia_core

// [tb/rsia_mem_model.sv]
module rsia_mem_model
  import rsia_pkg::*;
(
  input  wire logic          core_clk,
  input  wire rsia_mem_req_s mem_req,
  output logic [DATA_W-1:0]  mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DATA_W-1:0] mem [256];
  // idle answer toggles so a stale byte never looks valid
  always_ff @(posedge core_clk) begin
    if (mem_req.wr)
      mem[mem_req.addr[7:0]] <= mem_req.wdata;
    mem_rdata <= mem_req.rd ? mem[mem_req.addr[7:0]] : ~mem_rdata;
  end
endmodule : rsia_mem_model

// [tb/rsia_core_sva.sv]
module rsia_core_sva
  import rsia_pkg::*;
(
  input wire logic                   core_clk, rst_n, stack_reset_enable, push, pop,
  input wire logic                   device_reset_req, stack_overflow_flag, stack_underflow_flag,
  input wire logic [1:0]             ptr_wr_high,
  input wire logic [STACK_PTR_W-1:0] stack_level_pointer,
  input wire logic [DATA_W-1:0]      ptr_wdata, ind_rdata,
  input wire logic [IND_ADDR_W-1:0]  file_select_pointer0, file_select_pointer1,
  input wire rsia_ind_req_s          ind_req,
  input wire rsia_mem_req_s          mem_req
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [IND_ADDR_W-1:0] fsp;
  logic                  win, full, unf;
  assign fsp = ind_req.sel ? file_select_pointer1 : file_select_pointer0;
  assign win = fsp inside {WINDOW0_ADDR, WINDOW1_ADDR};
  assign full = push && stack_level_pointer == STACK_PTR_TOP;
  assign unf = pop && !push && stack_level_pointer == STACK_PTR_EMPTY;
  property p_wrap; full && !stack_reset_enable |=> stack_level_pointer == STACK_PTR_WRAP;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap");
  property p_keep; full && stack_reset_enable |=> stack_level_pointer == STACK_PTR_RST; endproperty
  a_keep: assert property (p_keep) else $error("level zero hit");
  property p_ovf; full && stack_reset_enable |=> device_reset_req && stack_overflow_flag;
  endproperty
  a_ovf: assert property (p_ovf) else $error("no overflow reset");
  property p_unf; unf && stack_reset_enable |=> device_reset_req && stack_underflow_flag;
  endproperty
  a_unf: assert property (p_unf) else $error("no underflow reset");
  property p_addr; ind_req.valid && !win |-> mem_req.addr == fsp && mem_req.wr == ind_req.write;
  endproperty
  a_addr: assert property (p_addr) else $error("bad indirect access");
  property p_zero; ind_req.valid && !ind_req.write && win |=> ind_rdata == ZERO_BYTE; endproperty
  a_zero: assert property (p_zero) else $error("window read not zero");
  property p_nowr; ind_req.valid && win |-> !mem_req.wr && !mem_req.rd; endproperty
  a_nowr: assert property (p_nowr) else $error("window access passed");
  property p_high; ptr_wr_high[0] |=> file_select_pointer0[15:8] == $past(ptr_wdata); endproperty
  a_high: assert property (p_high) else $error("high byte lost");
endmodule : rsia_core_sva

bind rsia_core rsia_core_sva i_rsia_core_sva (.*);

// [tb/tb_top.sv]
module tb_top;
  import rsia_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   core_clk = 0, rst_n = 0, stack_reset_enable = 0, push = 0, pop = 0;
  logic                   cause_clear = 0, device_reset_req, stack_overflow_flag;
  logic                   stack_underflow_flag;
  logic [RET_ADDR_W-1:0]  push_addr = 'h0, top_return;
  logic [STACK_PTR_W-1:0] stack_level_pointer;
  logic [1:0]             ptr_wr_high = 'h0, ptr_wr_low = 'h0;
  logic [DATA_W-1:0]      ptr_wdata = 'h0, mem_rdata, ind_rdata;
  logic [IND_ADDR_W-1:0]  file_select_pointer0, file_select_pointer1;
  rsia_ind_req_s          ind_req = 'h0;
  rsia_mem_req_s          mem_req;
  int                     n_errors = 0, checked = 0;
  // sel, pointer, region
  logic [18:0]            rows [5] = '{{1'h0, 16'h0010, 2'h0}, {1'h1, 16'h2020, 2'h1},
                                       {1'h0, 16'h8030, 2'h2}, {1'h0, 16'h0000, 2'h0},
                                       {1'h1, 16'h0001, 2'h0}};
  rsia_core i_rsia_core (.*);
  rsia_mem_model i_rsia_mem_model (.*);
  always #2 core_clk = ~core_clk;
  task automatic tick(int n = 1);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic push_n(int n);
    for (int k = 0; k < n; k++) begin
      push_addr = k[14:0];
      push = 1;
      tick();
    end
    push = 0;
  endtask : push_n
  task automatic test_done;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  initial begin
    logic        w;
    logic [15:0] a;
    logic [7:0]  d;
    tick(8);
    rst_n = 1;
    chk("ptr", stack_level_pointer, 5'h1f);
    foreach (rows[i]) begin
      a = rows[i][17:2];
      d = a[7:0] ^ 8'h5a;
      w = a inside {WINDOW0_ADDR, WINDOW1_ADDR};
      ptr_wr_high[rows[i][18]] = 1;
      ptr_wdata = a[15:8];
      tick();
      ptr_wr_high = 0;
      ptr_wr_low[rows[i][18]] = 1;
      ptr_wdata = a[7:0];
      tick();
      ptr_wr_low = 0;
      chk("fsp", rows[i][18] ? file_select_pointer1 : file_select_pointer0, a);
      ind_req = '{1'b1, 1'b1, rows[i][18], d};
      #1;
      chk("wr", mem_req.wr, !w);
      if (!w) chk("region", mem_req.region, rows[i][1:0]);
      tick();
      ind_req.write = 0;
      tick();
      ind_req.valid = 0;
      chk("rdata", ind_rdata, w ? 8'h00 : d);
    end
    $display("indirect test done");
    push_n(17);
    chk("wrap", stack_level_pointer, 5'h10);
    chk("tos", top_return, 15'h10);
    rst_n = 0;
    tick();
    rst_n = 1;
    stack_reset_enable = 1;
    push_n(17);
    chk("ovf", {device_reset_req, stack_overflow_flag}, 2'h3);
    chk("keep", stack_level_pointer, 5'h1f);
    cause_clear = 1;
    tick();
    cause_clear = 0;
    pop = 1;
    tick();
    pop = 0;
    chk("unf", {device_reset_req, stack_underflow_flag, stack_overflow_flag}, 3'h6);
    stack_reset_enable = 0;
    pop = 1;
    tick(15);
    pop = 0;
    chk("lvl0", top_return, 15'h0);
    $display("stack test done");
    test_done();
  end
endmodule : tb_top
